// ---- include/rcd_pkg.sv ----
// Shared constants and types for the 14-bit instruction decoder core.
package rcd_pkg;

   // Instruction word layout.
   localparam int INS_W = 14;
   localparam int CLS_HI = 13;
   localparam int CLS_LO = 12;
   localparam int OP_HI = 11;
   localparam int OP_LO = 8;
   localparam int DST_BIT = 7;
   localparam int FA_HI = 6;
   localparam int BOP_HI = 11;
   localparam int BOP_LO = 10;
   localparam int BIX_HI = 9;
   localparam int BIX_LO = 7;
   localparam int LIT_HI = 7;
   localparam int CALL_JMP_BIT = 11;

   // Instruction classes.
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_BRANCH = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;

   // Byte-class opcodes.
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_OR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOVE_FILE = 4'h8;
   localparam logic [3:0] OP_COM = 4'h9;
   localparam logic [3:0] OP_INC = 4'ha;
   localparam logic [3:0] OP_DECSZ = 4'hb;
   localparam logic [3:0] OP_RRC = 4'hc;
   localparam logic [3:0] OP_RLC = 4'hd;
   localparam logic [3:0] OP_SWAP = 4'he;
   localparam logic [3:0] OP_INCSZ = 4'hf;

   // Fixed low bytes of the class 00, opcode 0000 control codes.
   localparam logic [7:0] CODE_RETURN = 8'h08;
   localparam logic [7:0] CODE_RETFI = 8'h09;
   localparam logic [7:0] CODE_SLEEP = 8'h63;
   localparam logic [7:0] CODE_WDCLR = 8'h64;

   // File register map and status bit positions.
   localparam int RAM_D = 128;
   localparam logic [6:0] FA_TIMER_ZERO_COUNT = 7'h01;
   localparam logic [6:0] FA_STATUS = 7'h03;
   localparam logic [6:0] FA_PORT = 7'h06;
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;

   // Timing: oscillator periods per instruction cycle.
   localparam int OSC_PER_CYC = 4;

   // APB register map.
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] ADDR_STAT = 12'h004;
   localparam logic [APB_AW-1:0] ADDR_ACC = 12'h008;
   localparam int CTRL_RUN = 0;
   localparam logic CTRL_RUN_RST = 1'b0;
   localparam int STAT_GIE = 8;
   localparam int STAT_HALT = 9;
   localparam int STAT_PC_LSB = 16;

   // Instruction cycle phases, Gray coded.
   typedef enum logic [1:0] {
      PH_Q1 = 2'h0,
      PH_Q2 = 2'h1,
      PH_Q3 = 2'h3,
      PH_Q4 = 2'h2
   } rcd_phase_t;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0,
      ALU_SUB = 4'h1,
      ALU_AND = 4'h2,
      ALU_OR = 4'h3,
      ALU_XOR = 4'h4,
      ALU_COM = 4'h5,
      ALU_DEC = 4'h6,
      ALU_INC = 4'h7,
      ALU_RLC = 4'h8,
      ALU_RRC = 4'h9,
      ALU_SWP = 4'ha,
      ALU_PASS = 4'hb,
      ALU_CLR = 4'hc
   } rcd_alu_op_t;

endpackage

// ---- include/rcd_alu_if.sv ----
// Operand and result bundle between the core and its arithmetic unit.
`timescale 1ns/1ps
interface rcd_alu_if;
   import rcd_pkg::*;
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   rcd_alu_op_t op;
   logic [7:0] r;
   logic c;
   logic dc;
   logic z;
   modport alu (input a, input b, input cin, input op,
                output r, output c, output dc, output z);
   modport core (output a, output b, output cin, output op,
                 input r, input c, input dc, input z);
endinterface

// ---- design/rcd_alu.sv ----
// Eight-bit arithmetic and logic unit with carry and digit carry.
`timescale 1ns/1ps
module rcd_alu (
   // Operands in, result and flags out
   rcd_alu_if.alu bus
);
   import rcd_pkg::*;

   logic [8:0] s9;
   logic [4:0] n5;

   // Subtraction adds the inverted subtrahend plus one, so carry reads
   // as "no borrow", matching the flag convention of the core.
   always_comb begin
      s9 = 9'h000;
      n5 = 5'h00;
      unique case (bus.op)
         ALU_ADD: begin
            s9 = {1'b0, bus.a} + {1'b0, bus.b};
            n5 = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
         end
         ALU_SUB: begin
            s9 = {1'b0, bus.a} + {1'b0, ~bus.b} + 9'h001;
            n5 = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + 5'h01;
         end
         ALU_AND: s9 = {1'b0, bus.a & bus.b};
         ALU_OR: s9 = {1'b0, bus.a | bus.b};
         ALU_XOR: s9 = {1'b0, bus.a ^ bus.b};
         ALU_COM: s9 = {1'b0, ~bus.a};
         ALU_DEC: s9 = {1'b0, bus.a - 8'h01};
         ALU_INC: s9 = {1'b0, bus.a + 8'h01};
         ALU_RLC: s9 = {bus.a, bus.cin};
         ALU_RRC: s9 = {bus.a[0], bus.cin, bus.a[7:1]};
         ALU_SWP: s9 = {1'b0, bus.a[3:0], bus.a[7:4]};
         ALU_PASS: s9 = {1'b0, bus.a};
         ALU_CLR: s9 = 9'h000;
      endcase
      bus.r = s9[7:0];
      bus.c = s9[8];
      bus.dc = n5[4];
      bus.z = (s9[7:0] == 8'h00);
   end

endmodule

// ---- design/rcd_core.sv ----
// Instruction decoder and execution core with APB control registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Contract
// - Add literal or register, update C DC Z
// - AND literal into accumulator, zero only
// - OR literal into accumulator, zero only
// - XOR literal updates zero; load literal flagless
// - Subtract register or literal minus accumulator
// - Register OR XOR AND, zero only
// - Rotate through carry, only carry changes
// - Decrement sets zero; skip form skips
// - Increment sets zero; skip form skips
// - Bit clear and set, one cycle
// - Bit tests skip on clear or set
// - Successful test runs a no-operation next
// - Call and jump take two cycles
// - Return pops stack, two cycles, flags kept
// - Interrupt return pops stack, two cycles
// - Return with literal loads accumulator
// - Standby sets TO and clears PD; watchdog clear sets TO PD
// - Port rewrite reads pin levels
// - Timer count write clears assigned prescaler
// - Destination bit picks accumulator or file
// - Instruction cycle is four clocks
module rcd_core #(
   parameter int PC_W = 11,
   parameter int STK_D = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [rcd_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Program memory
   output logic [PC_W-1:0] prog_addr_o,
   input wire logic [rcd_pkg::INS_W-1:0] instr_i,
   // I/O port
   input wire logic [7:0] port_pins_i,
   output logic [7:0] port_latch_o,
   // Timer, watchdog and standby
   input wire logic presc_to_timer_i,
   output logic presc_clear_o,
   output logic wdt_clear_o,
   input wire logic wake_i,
   output logic sleep_o
);
   import rcd_pkg::*;

   localparam int SP_W = $clog2(STK_D);

   if (PC_W < 8 || PC_W > 11 || STK_D < 2 ||
       (STK_D & (STK_D - 1)) != 0 || OSC_PER_CYC != 4) begin : g_bad
      $error("rcd_core: unsupported PC_W or STK_D");
   end

   typedef struct packed {
      rcd_phase_t ph;
      logic [PC_W-1:0] pc;
      logic [STK_D-1:0][PC_W-1:0] stk;
      logic [SP_W-1:0] sp;
      logic [7:0] w;
      logic c;
      logic dc;
      logic z;
      logic to;
      logic pd;
      logic gie;
      logic flush;
      logic keep_pc;
      logic halt;
      logic run;
      logic presc_clr;
      logic wdt_clr;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
      logic [RAM_D-1:0][7:0] ram;
   } rcd_state_t;

   localparam rcd_state_t RST_STATE = '{
      ph: PH_Q1,
      to: 1'b1,
      pd: 1'b1,
      run: CTRL_RUN_RST,
      default: '0
   };

   rcd_state_t s_reg;
   rcd_state_t s_next;
   rcd_alu_if alu_bus ();

   rcd_alu u_alu (
      .bus (alu_bus.alu)
   );

   ////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
      return p + 1'b1;
   endfunction

   function automatic logic [7:0] stat_byte(input rcd_state_t st);
      logic [7:0] v;
      v = 8'h00;
      v[ST_C] = st.c;
      v[ST_DC] = st.dc;
      v[ST_Z] = st.z;
      v[ST_PD] = st.pd;
      v[ST_TO] = st.to;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Decode

   logic [1:0] cls;
   logic [3:0] op4;
   logic dsel;
   logic [6:0] fa;
   logic [2:0] bix;
   logic [7:0] lit;
   logic [7:0] fval;

   assign cls = instr_i[CLS_HI:CLS_LO];
   assign op4 = instr_i[OP_HI:OP_LO];
   assign dsel = instr_i[DST_BIT];
   assign fa = instr_i[FA_HI:0];
   assign bix = instr_i[BIX_HI:BIX_LO];
   assign lit = instr_i[LIT_HI:0];

   // Read-modify-write of the port uses the pins, so an input pin held
   // low by the outside reads back low whatever its latch holds.
   always_comb begin
      if (fa == FA_PORT) begin
         fval = port_pins_i;
      end else if (fa == FA_STATUS) begin
         fval = stat_byte(s_reg);
      end else begin
         fval = s_reg.ram[fa];
      end
   end

   always_comb begin
      alu_bus.a = fval;
      alu_bus.b = s_reg.w;
      alu_bus.cin = s_reg.c;
      alu_bus.op = ALU_PASS;
      if (cls == CLS_BYTE) begin
         unique case (op4)
            OP_MISC: alu_bus.a = s_reg.w;
            OP_CLR: alu_bus.op = ALU_CLR;
            OP_SUB: alu_bus.op = ALU_SUB;
            OP_DEC, OP_DECSZ: alu_bus.op = ALU_DEC;
            OP_OR: alu_bus.op = ALU_OR;
            OP_AND: alu_bus.op = ALU_AND;
            OP_XOR: alu_bus.op = ALU_XOR;
            OP_ADD: alu_bus.op = ALU_ADD;
            OP_MOVE_FILE: alu_bus.op = ALU_PASS;
            OP_COM: alu_bus.op = ALU_COM;
            OP_INC, OP_INCSZ: alu_bus.op = ALU_INC;
            OP_RRC: alu_bus.op = ALU_RRC;
            OP_RLC: alu_bus.op = ALU_RLC;
            OP_SWAP: alu_bus.op = ALU_SWP;
         endcase
      end else if (cls == CLS_LIT) begin
         alu_bus.a = lit;
         unique casez (op4)
            4'b111?: alu_bus.op = ALU_ADD;
            4'b110?: alu_bus.op = ALU_SUB;
            4'b1001: alu_bus.op = ALU_AND;
            4'b1000: alu_bus.op = ALU_OR;
            4'b1010: alu_bus.op = ALU_XOR;
            default: alu_bus.op = ALU_PASS;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic wr_en;
      logic [6:0] wr_a;
      logic [7:0] wr_d;
      logic up_c;
      logic up_dc;
      logic up_z;
      logic [7:0] mask;
      wr_en = 1'b0;
      wr_a = fa;
      wr_d = alu_bus.r;
      up_c = 1'b0;
      up_dc = 1'b0;
      up_z = 1'b0;
      mask = 8'h01 << bix;
      s_next = s_reg;
      s_next.presc_clr = 1'b0;
      s_next.wdt_clr = 1'b0;
      s_next.ready = 1'b0;
      s_next.slverr = 1'b0;

      // APB: read data is captured in the setup cycle and the answer
      // comes in the first access cycle; writes land at that edge.
      if (psel_i && !penable_i) begin
         s_next.ready = 1'b1;
         s_next.rdata = 32'h0000_0000;
         if (paddr_i == ADDR_CTRL) begin
            s_next.rdata[CTRL_RUN] = s_reg.run;
         end else if (paddr_i == ADDR_STAT) begin
            s_next.rdata[7:0] = stat_byte(s_reg);
            s_next.rdata[STAT_GIE] = s_reg.gie;
            s_next.rdata[STAT_HALT] = s_reg.halt;
            s_next.rdata[STAT_PC_LSB +: PC_W] = s_reg.pc;
         end else if (paddr_i == ADDR_ACC) begin
            s_next.rdata[7:0] = s_reg.w;
         end else begin
            s_next.slverr = 1'b1;
         end
      end
      if (psel_i && penable_i && s_reg.ready && pwrite_i &&
          paddr_i == ADDR_CTRL) begin
         s_next.run = pwdata_i[CTRL_RUN];
      end

      if (s_reg.halt && wake_i) begin
         s_next.halt = 1'b0;
      end

      // One instruction cycle is four clocks; work happens in the last.
      if (s_reg.run && !s_reg.halt) begin
         unique case (s_reg.ph)
            PH_Q1: s_next.ph = PH_Q2;
            PH_Q2: s_next.ph = PH_Q3;
            PH_Q3: s_next.ph = PH_Q4;
            PH_Q4: s_next.ph = PH_Q1;
         endcase
      end

      if (s_reg.run && !s_reg.halt && s_reg.ph == PH_Q4) begin
         if (s_reg.flush) begin
            // Second cycle of a skip or branch: the fetched word is
            // dropped. After a branch the target is already in pc.
            s_next.flush = 1'b0;
            s_next.keep_pc = 1'b0;
            if (!s_reg.keep_pc) begin
               s_next.pc = pc_inc(s_reg.pc);
            end
         end else begin
            s_next.pc = pc_inc(s_reg.pc);
            unique case (cls)
               CLS_BYTE: begin
                  if (op4 == OP_MISC) begin
                     if (dsel) begin
                        wr_en = 1'b1;
                        wr_d = s_reg.w;
                     end else if (lit == CODE_RETURN ||
                                  lit == CODE_RETFI) begin
                        s_next.sp = s_reg.sp - 1'b1;
                        s_next.pc = s_reg.stk[s_reg.sp - 1'b1];
                        s_next.flush = 1'b1;
                        s_next.keep_pc = 1'b1;
                        if (lit == CODE_RETFI) begin
                           s_next.gie = 1'b1;
                        end
                     end else if (lit == CODE_SLEEP) begin
                        s_next.to = 1'b1;
                        s_next.pd = 1'b0;
                        s_next.halt = 1'b1;
                        s_next.wdt_clr = 1'b1;
                     end else if (lit == CODE_WDCLR) begin
                        s_next.to = 1'b1;
                        s_next.pd = 1'b1;
                        s_next.wdt_clr = 1'b1;
                     end
                  end else begin
                     if (dsel) begin
                        wr_en = 1'b1;
                     end else begin
                        s_next.w = alu_bus.r;
                     end
                     unique case (op4)
                        OP_ADD, OP_SUB: begin
                           up_c = 1'b1;
                           up_dc = 1'b1;
                           up_z = 1'b1;
                        end
                        OP_RLC, OP_RRC: up_c = 1'b1;
                        OP_SWAP: up_z = 1'b0;
                        OP_DECSZ, OP_INCSZ: begin
                           if (alu_bus.z) begin
                              s_next.flush = 1'b1;
                           end
                        end
                        default: up_z = 1'b1;
                     endcase
                  end
               end
               CLS_BIT: begin
                  unique case (instr_i[BOP_HI:BOP_LO])
                     2'h0: begin
                        wr_en = 1'b1;
                        wr_d = fval & ~mask;
                     end
                     2'h1: begin
                        wr_en = 1'b1;
                        wr_d = fval | mask;
                     end
                     2'h2: s_next.flush = ~|(fval & mask);
                     2'h3: s_next.flush = |(fval & mask);
                  endcase
               end
               CLS_BRANCH: begin
                  if (!instr_i[CALL_JMP_BIT]) begin
                     s_next.stk[s_reg.sp] = pc_inc(s_reg.pc);
                     s_next.sp = s_reg.sp + 1'b1;
                  end
                  s_next.pc = instr_i[PC_W-1:0];
                  s_next.flush = 1'b1;
                  s_next.keep_pc = 1'b1;
               end
               CLS_LIT: begin
                  unique casez (op4)
                     4'b00??: s_next.w = lit;
                     4'b01??: begin
                        s_next.w = lit;
                        s_next.sp = s_reg.sp - 1'b1;
                        s_next.pc = s_reg.stk[s_reg.sp - 1'b1];
                        s_next.flush = 1'b1;
                        s_next.keep_pc = 1'b1;
                     end
                     4'b11??: begin
                        s_next.w = alu_bus.r;
                        up_c = 1'b1;
                        up_dc = 1'b1;
                        up_z = 1'b1;
                     end
                     4'b1000, 4'b1001, 4'b1010: begin
                        s_next.w = alu_bus.r;
                        up_z = 1'b1;
                     end
                     default: s_next.w = s_reg.w;
                  endcase
               end
            endcase
         end
      end

      // File write first, flag updates after, so an operation that
      // targets the status byte still leaves its own flags correct.
      if (wr_en) begin
         if (wr_a == FA_STATUS) begin
            s_next.c = wr_d[ST_C];
            s_next.dc = wr_d[ST_DC];
            s_next.z = wr_d[ST_Z];
         end else begin
            s_next.ram[wr_a] = wr_d;
         end
         if (wr_a == FA_TIMER_ZERO_COUNT && presc_to_timer_i) begin
            s_next.presc_clr = 1'b1;
         end
      end
      if (up_c) begin
         s_next.c = alu_bus.c;
      end
      if (up_dc) begin
         s_next.dc = alu_bus.dc;
      end
      if (up_z) begin
         s_next.z = alu_bus.z;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata_o = s_reg.rdata;
   assign pready_o = s_reg.ready;
   assign pslverr_o = s_reg.slverr;
   assign prog_addr_o = s_reg.pc;
   assign port_latch_o = s_reg.ram[FA_PORT];
   assign presc_clear_o = s_reg.presc_clr;
   assign wdt_clear_o = s_reg.wdt_clr;
   assign sleep_o = s_reg.halt;

endmodule

// ---- verification/rcd_core_checker.sv ----
// Port-level assertions for the decoder core, bound into it.
`timescale 1ns/1ps
module rcd_core_checker
   import rcd_pkg::*;
#(
   parameter int PC_W = 11
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Fetch
   input wire logic [PC_W-1:0] prog_addr_o,
   input wire logic [INS_W-1:0] instr_i,
   // Timer, watchdog and standby
   input wire logic presc_to_timer_i,
   input wire logic presc_clear_o,
   input wire logic wdt_clear_o,
   input wire logic wake_i,
   input wire logic sleep_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   cycle_len_a: assert property ($changed(prog_addr_o) |=>
      $stable(prog_addr_o)[*3])
      else $error("Program counter moved inside a cycle.");
   branch_tgt_a: assert property ($changed(prog_addr_o) &&
      $past(instr_i[13:12]) == CLS_BRANCH |->
      prog_addr_o == $past(instr_i[PC_W-1:0]) ||
      prog_addr_o == $past(prog_addr_o) + 1'b1)
      else $error("Branch went to a wrong address.");
   // A taken branch is told from an ignored one by its target.
   branch_hold_a: assert property ($changed(prog_addr_o) &&
      $past(instr_i[13:12]) == CLS_BRANCH &&
      prog_addr_o != $past(prog_addr_o) + 1'b1 |=>
      $stable(prog_addr_o)[*7])
      else $error("Branch did not spend two cycles.");
   presc_src_a: assert property (presc_clear_o |->
      $past(presc_to_timer_i) ##1 !presc_clear_o)
      else $error("Prescaler clear without assignment.");
   wdt_pulse_a: assert property (wdt_clear_o |=> !wdt_clear_o)
      else $error("Watchdog clear longer than a clock.");
   sleep_hold_a: assert property (sleep_o && !wake_i |=> sleep_o)
      else $error("Standby ended without wake.");
   sleep_pc_a: assert property (sleep_o && $past(sleep_o) |->
      $stable(prog_addr_o))
      else $error("Program counter moved in standby.");
   wake_end_a: assert property (sleep_o && wake_i |=> !sleep_o)
      else $error("Wake did not end standby.");
   apb_ready_a: assert property (psel_i && !penable_i |=>
      pready_o ##1 !pready_o)
      else $error("Ready not a pulse after setup.");
   err_qual_a: assert property (pslverr_o |-> pready_o)
      else $error("Error without ready.");
endmodule
bind rcd_core rcd_core_checker #(.PC_W(PC_W)) u_chk (
   .clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
   .prog_addr_o, .instr_i, .presc_to_timer_i, .presc_clear_o,
   .wdt_clear_o, .wake_i, .sleep_o
);

// ---- verification/rcd_prog_mem.sv ----
// Program memory model answering each fetch address at once.
`timescale 1ns/1ps
module rcd_prog_mem #(
   parameter int AW = 11
) (
   // Fetch side
   input wire logic [AW-1:0] addr_i,
   output logic [13:0] data_o
);
   // Loaded by the bench; empty words read as no-operations.
   logic [13:0] mem [2**AW];
   initial begin
      foreach (mem[i]) mem[i] = 14'h0000;
   end
   assign data_o = mem[addr_i];
endmodule

// ---- verification/tb_risc_14bit_instruction_decoder.sv ----
// Self-checking bench running short programs on the decoder core.
`timescale 1ns/1ps
module tb_risc_14bit_instruction_decoder;
   import rcd_pkg::*;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [APB_AW-1:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o;
   logic pready_o, pslverr_o, presc_clear_o, wdt_clear_o, sleep_o;
   logic [10:0] prog_addr_o;
   logic [13:0] instr_i;
   logic [7:0] port_pins_i = 8'ha5, port_latch_o;
   logic presc_to_timer_i = 0, wake_i = 0, slept = 0;
   int miscompares = 0, checked = 0, ix = 0, ncl = 0, cyc = 0, nwd = 0;
   rcd_core dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .prog_addr_o, .instr_i, .port_pins_i, .port_latch_o,
      .presc_to_timer_i, .presc_clear_o, .wdt_clear_o, .wake_i,
      .sleep_o);
   rcd_prog_mem pm (.addr_i(prog_addr_o), .data_o(instr_i));
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (rst_i) begin
         ncl <= 0;
         nwd <= 0;
         slept <= 0;
      end else begin
         if (presc_clear_o) ncl <= ncl + 1;
         if (wdt_clear_o) nwd <= nwd + 1;
         if (sleep_o) slept <= 1;
      end
      if (cyc == 30000) begin
         miscompares++;
         end_of_test;
      end
   end
   ////////////////////////////////////////
   task end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [APB_AW-1:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      @(posedge clk_i);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task p(input logic [13:0] w);
      pm.mem[ix] = w;
      ix++;
   endtask
   // Ends the program with a self jump, runs it from reset until the
   // counter rests there, then checks the accumulator and status.
   task go(input logic [7:0] w, input logic [15:0] st, input int e = -1);
      logic [31:0] d;
      logic er;
      int n;
      int s;
      if (e < 0) e = ix;
      pm.mem[e] = 14'h2800 | 14'(e);
      ix = 0;
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      apb(1, ADDR_CTRL, 32'h1, d, er);
      n = 0;
      s = 0;
      while (n < 16) begin
         @(posedge clk_i);
         s = sleep_o ? s + 1 : 0;
         wake_i <= s > 6;
         n = (prog_addr_o == e && !sleep_o) ? n + 1 : 0;
      end
      apb(0, ADDR_ACC, 32'h0, d, er);
      chk(d, {24'h0, w});
      apb(0, ADDR_STAT, 32'h0, d, er);
      chk(d, {5'h0, 11'(e), st});
   endtask
   ////////////////////////////////////////
   task t_apb;
      logic [31:0] d;
      logic er;
      apb(0, ADDR_CTRL, 32'h0, d, er);
      chk(d, 32'h0);
      apb(1, ADDR_STAT, 32'hffff, d, er);
      apb(0, ADDR_STAT, 32'h0, d, er);
      chk(d, 32'h18);
      apb(0, 12'h00c, 32'h0, d, er);
      chk({31'h0, er}, 32'h1);
   endtask
   task t_lit;
      p(14'h3088);
      p(14'h3e78);
      go(8'h00, 16'h001f);
      p(14'h3088);
      p(14'h3e78);
      p(14'h30a3);
      p(14'h395f);
      go(8'h03, 16'h001b);
      p(14'h3000);
      p(14'h3800);
      go(8'h00, 16'h001c);
      p(14'h305a);
      p(14'h3a5a);
      p(14'h3041);
      go(8'h41, 16'h001c);
      p(14'h3001);
      p(14'h3c03);
      go(8'h02, 16'h001b);
   endtask
   task t_reg;
      p(14'h300f);
      p(14'h00a0);
      p(14'h303c);
      p(14'h0420);
      p(14'h0520);
      p(14'h06a0);
      p(14'h0820);
      go(8'h00, 16'h001c);
      p(14'h3005);
      p(14'h00a1);
      p(14'h3003);
      p(14'h0221);
      p(14'h07a1);
      p(14'h0821);
      go(8'h07, 16'h0018);
      p(14'h3081);
      p(14'h00a2);
      p(14'h0d22);
      p(14'h0ca2);
      p(14'h0822);
      go(8'hc0, 16'h0019);
      p(14'h3012);
      p(14'h00a0);
      p(14'h09a0);
      p(14'h0e20);
      go(8'hde, 16'h0018);
      p(14'h3012);
      p(14'h0103);
      go(8'h00, 16'h001c);
   endtask
   task t_skip;
      p(14'h3001);
      p(14'h00a3);
      p(14'h0ba3);
      p(14'h3055);
      go(8'h01, 16'h0018);
      p(14'h3001);
      p(14'h00a5);
      p(14'h0325);
      go(8'h00, 16'h001c);
      p(14'h30ff);
      p(14'h00a4);
      p(14'h0f24);
      p(14'h3066);
      go(8'h00, 16'h0018);
      p(14'h30ff);
      p(14'h00a6);
      p(14'h0a26);
      go(8'h00, 16'h001c);
      p(14'h3000);
      p(14'h00a7);
      p(14'h15a7);
      p(14'h1da7);
      p(14'h3077);
      p(14'h19a7);
      p(14'h3011);
      go(8'h11, 16'h0018);
      p(14'h30ff);
      p(14'h00a7);
      p(14'h11a7);
      p(14'h0827);
      go(8'hf7, 16'h0018);
      p(14'h30ff);
      p(14'h00a7);
      p(14'h11a7);
      p(14'h19a7);
      p(14'h3055);
      go(8'hff, 16'h0018);
   endtask
   task t_branch;
      p(14'h2802);
      p(14'h3055);
      go(8'h00, 16'h0018);
      p(14'h2003);
      p(14'h3e01);
      p(14'h0000);
      p(14'h3441);
      go(8'h42, 16'h0018, 2);
      p(14'h2003);
      p(14'h3e01);
      p(14'h0000);
      p(14'h3041);
      p(14'h0008);
      go(8'h42, 16'h0018, 2);
      p(14'h2003);
      p(14'h3e01);
      p(14'h0000);
      p(14'h3041);
      p(14'h0009);
      go(8'h42, 16'h0118, 2);
   endtask
   task t_misc;
      p(14'h3033);
      p(14'h0063);
      go(8'h33, 16'h0010);
      chk({31'h0, slept}, 32'h1);
      p(14'h0063);
      p(14'h0064);
      go(8'h00, 16'h0018);
      chk(32'(nwd), 32'h2);
      p(14'h30ff);
      p(14'h0086);
      p(14'h0a86);
      p(14'h0806);
      go(8'ha5, 16'h0018);
      chk({24'h0, port_latch_o}, 32'ha6);
      presc_to_timer_i <= 1;
      p(14'h0181);
      go(8'h00, 16'h001c);
      chk(32'(ncl), 32'h1);
      presc_to_timer_i <= 0;
      p(14'h0181);
      go(8'h00, 16'h001c);
      chk(32'(ncl), 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      t_apb;
      t_lit;
      t_reg;
      t_skip;
      t_branch;
      t_misc;
      end_of_test;
   end
endmodule
